// ==== acl_unit.sv ====
// acl action and count unit of one switch port
//
// Function
// - priority_mode keeps, raises, lowers or forces priority
// - remark_enable replaces tag pcp with remark_value
// - map_mode keeps, ors, ands or replaces lookup map
// - mask bit n is egress port n+1
// - timeout mode: 11-bit down-counter, interrupt on expiry
// - time_unit_sel picks microsecond or millisecond steps
// - packet mode: count matches, interrupt, restart
// - table holds sixteen matching/action/process entries
// - entry fields independent except in count mode
// - only count mode entries raise interrupts
// - count only the mac plus ethertype matches
// - per-port status and mask feed global pair
// - count value is concatenated action bits
// - match_mode zero disables the rule
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "acl_defines.svh"

module acl_unit #(
   parameter int P_MS_CYC = `ACL_MS_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // avalon-mm register slave
   input wire logic [6:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // packet from lookup and qos logic
   input wire logic i_pkt_valid,
   input wire logic i_act_hit,
   input wire logic [3:0] i_act_entry,
   input wire logic [15:0] i_cnt_match,
   input wire logic [2:0] i_qos_prio,
   input wire logic [2:0] i_pcp,
   input wire logic [`ACL_NPORT-1:0] i_lookup_map,
   // action result
   output logic o_res_valid,
   output logic [2:0] o_prio,
   output logic [2:0] o_pcp,
   output logic [`ACL_NPORT-1:0] o_fwd_map,
   // interrupt
   output logic o_irq
);

   // ------------------------------------------------------------
   // storage and control state
   // ------------------------------------------------------------
   logic [31:0] tbl [`ACL_NENT];
   logic [3:0] csel;
   logic pstat;
   logic pmask;
   logic gmask;
   logic [10:0] cnt;
   acl_pkg::acl_cstate_t cst;
   logic [15:0] tick_cnt;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic req;
   logic wr_go;
   logic in_tbl;
   logic [31:0] rd_mux;

   // a request is answered when waitrequest is seen low
   assign req = i_avs_read | i_avs_write;
   assign wr_go = i_avs_write & ~o_avs_waitrequest;
   assign in_tbl = (i_avs_address[6] == 1'h0);

   // byte enables merge new data into an old word
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // waitrequest drops for one cycle per request
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'h1;
      end else if (req && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'h0;
      end else begin
         o_avs_waitrequest <= 1'h1;
      end
   end

   // ------------------------------------------------------------
   // acl table
   // ------------------------------------------------------------

   // one word per entry, written over the bus
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         for (int i = 0; i < `ACL_NENT; i++) begin
            tbl[i] <= 32'h0;
         end
      end else if (wr_go && in_tbl) begin
         tbl[i_avs_address[5:2]] <= be_merge(tbl[i_avs_address[5:2]],
            i_avs_writedata, i_avs_byteenable);
      end
   end

   // count entry select
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         csel <= 4'h0;
      end else if (wr_go && i_avs_address == `ACL_CSEL && i_avs_byteenable[0]) begin
         csel <= i_avs_writedata[3:0];
      end
   end

   // ------------------------------------------------------------
   // action path
   // ------------------------------------------------------------
   logic [31:0] ent;
   logic ent_cnt_mode;
   logic act_ok;
   logic [2:0] pval;
   logic [`ACL_NPORT-1:0] fmask;
   logic [2:0] next_prio;
   logic [2:0] next_pcp;
   logic [`ACL_NPORT-1:0] next_map;

   assign ent = tbl[i_act_entry];
   assign ent_cnt_mode = (ent[`ACL_F_MD +: 2] == `ACL_MD_L2) &&
      (ent[`ACL_F_ENB +: 2] == `ACL_ENB_CNT);
   // disabled rules and count entries take no action
   assign act_ok = i_act_hit && (ent[`ACL_F_MD +: 2] != 2'h0)
      && !ent_cnt_mode;
   assign pval = ent[`ACL_F_PV +: 3];
   // bit 0 of the mask is egress port 1
   assign fmask = ent[`ACL_F_FWD +: `ACL_NPORT];

   // priority override
   always_comb begin
      next_prio = i_qos_prio;
      if (act_ok) begin
         unique case (acl_pkg::acl_pmode_t'(ent[`ACL_F_PM +: 2]))
            acl_pkg::ACL_PM_KEEP: next_prio = i_qos_prio;
            acl_pkg::ACL_PM_HIGHER: begin
               if (pval > i_qos_prio) begin
                  next_prio = pval;
               end
            end
            acl_pkg::ACL_PM_LOWER: begin
               if (pval < i_qos_prio) begin
                  next_prio = pval;
               end
            end
            acl_pkg::ACL_PM_ALWAYS: next_prio = pval;
         endcase
      end
   end

   // vlan priority remark
   always_comb begin
      next_pcp = i_pcp;
      if (act_ok && ent[`ACL_F_RPE]) begin
         next_pcp = ent[`ACL_F_RV +: 3];
      end
   end

   // forwarding map combine
   always_comb begin
      next_map = i_lookup_map;
      if (act_ok) begin
         unique case (acl_pkg::acl_mmode_t'(ent[`ACL_F_MM +: 2]))
            acl_pkg::ACL_MM_KEEP: next_map = i_lookup_map;
            acl_pkg::ACL_MM_OR: next_map = i_lookup_map | fmask;
            acl_pkg::ACL_MM_AND: next_map = i_lookup_map & fmask;
            acl_pkg::ACL_MM_REPLACE: next_map = fmask;
         endcase
      end
   end

   // result registers, one cycle after the packet
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_res_valid <= 1'h0;
         o_prio <= 3'h0;
         o_pcp <= 3'h0;
         o_fwd_map <= '0;
      end else begin
         o_res_valid <= i_pkt_valid;
         if (i_pkt_valid) begin
            o_prio <= next_prio;
            o_pcp <= next_pcp;
            o_fwd_map <= next_map;
         end
      end
   end

   // ------------------------------------------------------------
   // count unit
   // ------------------------------------------------------------
   logic [31:0] cent;
   logic cnt_mode;
   logic [10:0] cval;
   logic tu;
   logic ca;
   logic qual;
   logic [15:0] tick_lim;
   logic tick;
   logic fire;
   logic csel_wr;
   logic [11:0] cnt_inc;

   assign cent = tbl[csel];
   assign cnt_mode = (cent[`ACL_F_MD +: 2] == `ACL_MD_L2) &&
      (cent[`ACL_F_ENB +: 2] == `ACL_ENB_CNT);
   // count value reuses the action fields
   assign cval = cent[`ACL_F_CV +: 11];
   assign tu = cent[`ACL_F_TU];
   assign ca = cent[`ACL_F_CA];
   // only mac plus ethertype matches of the count entry qualify
   assign qual = i_pkt_valid && i_cnt_match[csel] && cnt_mode;
   assign csel_wr = wr_go && (i_avs_address == `ACL_CSEL);
   assign cnt_inc = {1'h0, cnt} + 12'h001;

   // step length in clock cycles
   assign tick_lim = tu ? 16'(P_MS_CYC - 1) : 16'(`ACL_US_CYC - 1);
   assign tick = (tick_cnt == tick_lim);

   // expiry or terminal count, only in count mode
   always_comb begin
      fire = 1'h0;
      if (cnt_mode && !csel_wr) begin
         if (!ca) begin
            fire = !qual && (cst == acl_pkg::ACL_CNT_RUN) && tick
               && (cnt <= 11'h001);
         end else begin
            fire = qual && (cnt_inc >= {1'h0, cval});
         end
      end
   end

   // step prescaler, restarted by every reload
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         tick_cnt <= 16'h0;
      end else if (qual || tick || cst == acl_pkg::ACL_CNT_IDLE || ca) begin
         tick_cnt <= 16'h0;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end

   // counter and its state
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cst <= acl_pkg::ACL_CNT_IDLE;
         cnt <= 11'h0;
      end else if (!cnt_mode || csel_wr) begin
         cst <= acl_pkg::ACL_CNT_IDLE;
         cnt <= 11'h0;
      end else if (!ca) begin
         if (qual) begin
            cst <= acl_pkg::ACL_CNT_RUN;
            cnt <= cval;
         end else if (fire) begin
            cst <= acl_pkg::ACL_CNT_IDLE;
            cnt <= 11'h0;
         end else if (cst == acl_pkg::ACL_CNT_RUN && tick) begin
            cnt <= cnt - 11'h001;
         end
      end else begin
         cst <= acl_pkg::ACL_CNT_RUN;
         if (fire) begin
            cnt <= 11'h0;
         end else if (qual) begin
            cnt <= cnt_inc[10:0];
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status and masks
   // ------------------------------------------------------------
   logic pstat_clr;
   logic gstat;

   assign pstat_clr = wr_go && (i_avs_address == `ACL_PSTAT) &&
      i_avs_byteenable[0] && i_avs_writedata[0];
   assign gstat = pstat && !pmask;

   // sticky status, a new event wins over the clear
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pstat <= 1'h0;
      end else if (fire) begin
         pstat <= 1'h1;
      end else if (pstat_clr) begin
         pstat <= 1'h0;
      end
   end

   // port and global masks, 1 blocks
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pmask <= `ACL_MASK_RST;
         gmask <= `ACL_MASK_RST;
      end else if (wr_go && i_avs_byteenable[0]) begin
         if (i_avs_address == `ACL_PMASK) begin
            pmask <= i_avs_writedata[0];
         end
         if (i_avs_address == `ACL_GMASK) begin
            gmask <= i_avs_writedata[0];
         end
      end
   end

   // interrupt output through both mask levels
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_irq <= 1'h0;
      end else begin
         o_irq <= gstat && !gmask;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------

   // register read mux, unmapped reads zero
   always_comb begin
      rd_mux = 32'h0;
      if (in_tbl) begin
         rd_mux = tbl[i_avs_address[5:2]];
      end else begin
         unique case (i_avs_address)
            `ACL_PSTAT: rd_mux = {31'h0, pstat};
            `ACL_PMASK: rd_mux = {31'h0, pmask};
            `ACL_GSTAT: rd_mux = {31'h0, gstat};
            `ACL_GMASK: rd_mux = {31'h0, gmask};
            `ACL_CSEL: rd_mux = {28'h0, csel};
            `ACL_CNT: rd_mux = {20'h0, cst, cnt};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   // read data latched as waitrequest drops
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_avs_readdata <= 32'h0;
      end else if (i_avs_read && o_avs_waitrequest) begin
         o_avs_readdata <= rd_mux;
      end
   end

endmodule : acl_unit

// ==== acl_defines.svh ====
// offsets, field positions, reset values and timing counts of the acl unit
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ACL_TBL_BASE 7'h00
`define ACL_PSTAT 7'h40
`define ACL_PMASK 7'h44
`define ACL_GSTAT 7'h48
`define ACL_GMASK 7'h4C
`define ACL_CSEL 7'h50
`define ACL_CNT 7'h54

// ------------------------------------------------------------
// entry word field positions
// ------------------------------------------------------------
`define ACL_F_MD 0
`define ACL_F_ENB 2
`define ACL_F_PM 4
`define ACL_F_PV 6
`define ACL_F_RPE 9
`define ACL_F_RV 10
`define ACL_F_MM 13
`define ACL_F_FWD 15
`define ACL_F_TU 22
`define ACL_F_CA 23
`define ACL_F_CV 4

// ------------------------------------------------------------
// sizes, reset values and field codes
// ------------------------------------------------------------
`define ACL_NPORT 7
`define ACL_NENT 16
`define ACL_MASK_RST 1'h1
`define ACL_MD_L2 2'h1
`define ACL_ENB_CNT 2'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ACL_CLK_NS 25
`define ACL_US_NS 1000
`define ACL_US_CYC (`ACL_US_NS / `ACL_CLK_NS)
`define ACL_MS_CYC 40000

`endif

// ==== acl_pkg.sv ====
// types shared by the acl action and count unit
package acl_pkg;

   // priority override modes
   typedef enum logic [1:0] {
      ACL_PM_KEEP = 2'h0,
      ACL_PM_HIGHER = 2'h1,
      ACL_PM_LOWER = 2'h2,
      ACL_PM_ALWAYS = 2'h3
   } acl_pmode_t;

   // forwarding map combine modes
   typedef enum logic [1:0] {
      ACL_MM_KEEP = 2'h0,
      ACL_MM_OR = 2'h1,
      ACL_MM_AND = 2'h2,
      ACL_MM_REPLACE = 2'h3
   } acl_mmode_t;

   // count unit state
   typedef enum logic {
      ACL_CNT_IDLE = 1'h0,
      ACL_CNT_RUN = 1'h1
   } acl_cstate_t;

endpackage : acl_pkg

// ==== acl_unit_properties.sv ====
// port checker of the acl action and count unit
`timescale 1ns/10ps
module acl_unit_checker (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // register bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   // packet in
   input wire logic i_pkt_valid,
   input wire logic i_act_hit,
   input wire logic [2:0] i_qos_prio,
   input wire logic [2:0] i_pcp,
   input wire logic [6:0] i_lookup_map,
   // result and interrupt
   input wire logic o_res_valid,
   input wire logic [2:0] o_prio,
   input wire logic [2:0] o_pcp,
   input wire logic [6:0] o_fwd_map,
   input wire logic o_irq
);
   // one clock domain
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   // bus answers after exactly one wait
   a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("bus answer late");
   a_bus_low_once: assert property (!o_avs_waitrequest |-> ##1 o_avs_waitrequest)
      else $error("waitrequest low too long");
   // result follows each packet, and only a packet
   a_res_follows: assert property (i_pkt_valid |=> o_res_valid)
      else $error("no result after packet");
   a_res_caused: assert property (o_res_valid |-> $past(i_pkt_valid))
      else $error("result without packet");
   a_res_holds: assert property (!i_pkt_valid |=> $stable(o_prio) && $stable(o_pcp)
      && $stable(o_fwd_map)) else $error("result changed without packet");
   // no hit leaves the packet untouched
   a_miss_prio: assert property (i_pkt_valid && !i_act_hit |=> o_prio == $past(i_qos_prio))
      else $error("priority changed on miss");
   a_miss_pcp: assert property (i_pkt_valid && !i_act_hit |=> o_pcp == $past(i_pcp))
      else $error("pcp changed on miss");
   a_miss_map: assert property (i_pkt_valid && !i_act_hit |=> o_fwd_map == $past(i_lookup_map))
      else $error("map changed on miss");
   // interrupt stands until software writes
   a_irq_sticky: assert property (o_irq && !i_avs_write && !$past(i_avs_write) |=> o_irq)
      else $error("interrupt dropped without write");
   // main scenarios
   c_hit: cover property (i_pkt_valid && i_act_hit);
   c_irq: cover property ($rose(o_irq));
   c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : acl_unit_checker

bind acl_unit acl_unit_checker u_chk (.i_ref_clk, .i_rst, .i_avs_read, .i_avs_write,
   .o_avs_waitrequest, .i_pkt_valid, .i_act_hit, .i_qos_prio, .i_pcp, .i_lookup_map,
   .o_res_valid, .o_prio, .o_pcp, .o_fwd_map, .o_irq);

// ==== acl_pkt_src.sv ====
// packet source standing in for the lookup and qos datapath
`timescale 1ns/10ps
module acl_pkt_src (
   // clock
   input wire logic i_ref_clk,
   // packet towards the unit
   output logic o_pkt_valid,
   output logic o_act_hit,
   output logic [3:0] o_act_entry,
   output logic [15:0] o_cnt_match,
   output logic [2:0] o_qos_prio,
   output logic [2:0] o_pcp,
   output logic [6:0] o_lookup_map
);
   // idle lines at time zero
   initial begin
      o_pkt_valid = 1'h0;
      o_act_hit = 1'h0;
      o_act_entry = 4'h0;
      o_cnt_match = 16'h0;
      o_qos_prio = 3'h0;
      o_pcp = 3'h0;
      o_lookup_map = 7'h0;
   end
   // one packet for one edge, then hit, match, priority and map lines inverted
   task automatic send(input logic h, input logic [3:0] e, input logic [15:0] m,
      input logic [2:0] q, input logic [2:0] p, input logic [6:0] lm);
      @(posedge i_ref_clk);
      o_pkt_valid <= 1'h1;
      o_act_hit <= h;
      o_act_entry <= e;
      o_cnt_match <= m;
      o_qos_prio <= q;
      o_pcp <= p;
      o_lookup_map <= lm;
      @(posedge i_ref_clk);
      o_pkt_valid <= 1'h0;
      o_act_hit <= ~h;
      o_cnt_match <= ~m;
      o_qos_prio <= ~q;
      o_lookup_map <= ~lm;
   endtask : send
endmodule : acl_pkt_src

// ==== acl_unit_tb.sv ====
// self-checking bench of the acl action and count unit
`timescale 1ns/10ps
`include "acl_defines.svh"
module acl_unit_tb;
   logic clk, rst, rd, wr, wreq, pv, hit, res, irq;
   logic [6:0] addr, lmap, fmap;
   logic [31:0] wdata, rdata, q;
   logic [3:0] ent;
   logic [15:0] cm;
   logic [2:0] qp, pin, prio, pcp;
   int fails, checks;

   // design with a short millisecond
   acl_unit #(.P_MS_CYC(100)) dut (.i_ref_clk(clk), .i_rst(rst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pkt_valid(pv), .i_act_hit(hit),
      .i_act_entry(ent), .i_cnt_match(cm), .i_qos_prio(qp), .i_pcp(pin),
      .i_lookup_map(lmap), .o_res_valid(res), .o_prio(prio), .o_pcp(pcp),
      .o_fwd_map(fmap), .o_irq(irq));
   // datapath partner
   acl_pkt_src src (.i_ref_clk(clk), .o_pkt_valid(pv), .o_act_hit(hit), .o_act_entry(ent),
      .o_cnt_match(cm), .o_qos_prio(qp), .o_pcp(pin), .o_lookup_map(lmap));

   // 40 mhz clock
   always #12.5 clk = ~clk;

   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // one bus access held until waitrequest is seen low
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
      int n;
      // start right after an edge, never in mid-cycle after a packet check
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'h0 && n < 50);
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
      if (n >= 50) begin
         fails++;
         final_report();
      end
   endtask : bus

   // bounded wait for the interrupt
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'h1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("irq", irq, 1'h1);
      if (n >= lim) final_report();
   endtask : wait_irq

   // reset values and an unmapped read
   task automatic t_reset;
      bus(0, `ACL_PMASK, 0);
      chk("pmask", q, 1);
      bus(0, `ACL_GMASK, 0);
      chk("gmask", q, 1);
      bus(0, 7'h60, 0);
      chk("unmapped", q, 0);
   endtask : t_reset

   // every priority and map mode, remark on and off
   task automatic t_actions;
      logic [31:0] ew;
      logic [2:0] pe;
      logic [6:0] me [4] = '{7'h33, 7'h77, 7'h11, 7'h55};
      for (int i = 0; i < 4; i++) begin
         ew = (32'h55 << 15) | (i << 13) | (32'h5 << 10) | (i % 2 << 9) | (32'h4 << 6)
            | (i << 4) | 32'h2;
         bus(1, `ACL_TBL_BASE + 7'h8, ew);
         bus(0, `ACL_TBL_BASE + 7'h8, 0);
         chk("entry", q, ew);
         for (int k = 2; k < 7; k += 4) begin
            src.send(1'h1, 4'h2, 16'h0, 3'(k), 3'h1, 7'h33);
            #1;
            pe = (i == 0 || (i == 1 && k > 4) || (i == 2 && k < 4)) ? 3'(k) : 3'h4;
            chk("res", res, 1'h1);
            chk("prio", prio, pe);
            chk("pcp", pcp, (i % 2) ? 3'h5 : 3'h1);
            chk("map", fmap, me[i]);
         end
      end
      bus(1, `ACL_TBL_BASE + 7'hC, 32'h30);
      src.send(1'h1, 4'h3, 16'h0, 3'h6, 3'h2, 7'h2A);
      #1;
      chk("off prio", prio, 3'h6);
      src.send(1'h0, 4'h2, 16'h0, 3'h1, 3'h2, 7'h2A);
      #1;
      chk("miss map", fmap, 7'h2A);
   endtask : t_actions

   // packet count to three, masks and clear
   task automatic t_count;
      bus(1, `ACL_TBL_BASE + 7'h4, (32'h1 << 23) | (32'h3 << 4) | 32'h1);
      bus(1, `ACL_CSEL, 1);
      bus(1, `ACL_PMASK, 0);
      bus(1, `ACL_GMASK, 0);
      src.send(1'h1, 4'h1, 16'h2, 3'h2, 3'h1, 7'h1);
      #1;
      chk("count prio", prio, 3'h2);
      src.send(1'h0, 4'h0, 16'h1, 3'h2, 3'h1, 7'h1);
      src.send(1'h0, 4'h0, 16'h2, 3'h2, 3'h1, 7'h1);
      repeat (4) @(posedge clk);
      chk("irq early", irq, 1'h0);
      src.send(1'h0, 4'h0, 16'h2, 3'h2, 3'h1, 7'h1);
      wait_irq(6);
      bus(0, `ACL_CNT, 0);
      chk("cnt", q[10:0], 11'h0);
      bus(1, `ACL_PMASK, 1);
      bus(0, `ACL_GSTAT, 0);
      chk("gstat", q, 0);
      chk("irq masked", irq, 1'h0);
      bus(1, `ACL_PMASK, 0);
      bus(0, `ACL_PSTAT, 0);
      chk("pstat", q, 1);
      bus(1, `ACL_PSTAT, 1);
      // status clears at the answer edge, the output register one edge later
      repeat (2) @(posedge clk);
      chk("irq clear", irq, 1'h0);
   endtask : t_count

   // timeout of two steps, one reload in between
   task automatic t_timeout(input logic tu, input int lo, input int hi);
      bus(1, `ACL_TBL_BASE + 7'h4, (32'(tu) << 22) | (32'h2 << 4) | 32'h1);
      bus(1, `ACL_CSEL, 1);
      src.send(1'h0, 4'h0, 16'h2, 3'h0, 3'h0, 7'h0);
      repeat (lo - 5) @(posedge clk);
      src.send(1'h0, 4'h0, 16'h2, 3'h0, 3'h0, 7'h0);
      repeat (lo) @(posedge clk);
      chk("irq wait", irq, 1'h0);
      wait_irq(hi);
      bus(1, `ACL_PSTAT, 1);
   endtask : t_timeout

   // main sequence
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      rd = 1'h0;
      wr = 1'h0;
      addr = 7'h0;
      wdata = 32'h0;
      fails = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_reset();
      t_actions();
      t_count();
      t_timeout(1'h0, 35, 60);
      t_timeout(1'h1, 95, 130);
      final_report();
   end
endmodule : acl_unit_tb
